// file: ptr_result_bank.sv
/*
 * Pressure and temperature result bank behind a two-wire serial slave.
 * Holds live results, sample-to-sample changes, the part identifier and the
 * queue state byte; all are read-only and reached with auto-incrementing
 * register addresses, except that 01h does not advance while the queue is on.
 * Assumes samples, control bits and queue data arrive
 * from logic on the same 25 MHz clock; the bus pins are asynchronous.
 */
// Function
// - Pressure is unsigned 20 bits, two fraction bits
// - Pressure bytes at 01h, 02h, 03h high nibble
// - Pressure registers load only in barometer mode
// - Temperature is signed 12 bits, four fraction bits
// - Temperature at 04h and 05h high nibble
// - Address auto-increments across 00h to 0Dh, but holds at 01h with queue on
// - Queue off: registers show live samples
// - Pressure change at 07h-09h, same layout
// - Change registers update in every queue mode
// - Temperature change at 0Ah and 0Bh high nibble
// - Read-only part identifier at 0Ch
// - 0Dh: overflow, level flag, sample count
// - Count 0 empty, 1 to 32 stored
// - Overflow flag holds while queue overflowed
// - Level flag while count exceeds threshold
// - Reading 0Dh clears pending event, not flags
// - Queue on: 01h reads queue, 02h-05h zero
// - Queue off: reading 01h clears pressure flags
`timescale 1ns/1ns
module ptr_result_bank #(
	parameter logic [6:0] BUS_ADDRESS = ptr_pkg::BUS_ADDRESS_DFLT,
	parameter logic [7:0] PART_ID     = ptr_pkg::PART_ID_DFLT       // Arbitrary value
) (
	// Clock and reset
	input  wire logic                          clock,
	input  wire logic                          rstn,
	// Serial bus pins
	input  wire logic                          scl_in,
	input  wire logic                          sda_in,
	output logic                               sda_out,
	output logic                               sda_oe,
	// New sample from the acquisition engine
	input  wire logic                          sample_valid,
	input  wire logic [ptr_pkg::PRESS_W-1:0]   pressure_value,
	input  wire logic [ptr_pkg::TEMP_W-1:0]    temperature_value,
	// Control bits
	input  wire logic                          height_mode_select,
	input  wire logic [1:0]                    fifo_mode,
	input  wire logic [ptr_pkg::CNT_W-1:0]     queue_level_threshold,
	// Sample queue
	input  wire logic [ptr_pkg::CNT_W-1:0]     queue_fill_count,
	input  wire logic                          queue_overflowed,
	input  wire logic [7:0]                    fifo_data_byte,
	output logic                               fifo_data_take,
	output logic                               queue_event_pending
);
	import ptr_pkg::*;

	// --------------------------------------------------------------------
	// State
	// --------------------------------------------------------------------
	typedef struct packed {
		ptr_phase_t         phase;
		logic               scl_d;
		logic               sda_d;
		logic [3:0]         cnt;
		logic [7:0]         shreg;
		logic               rw;
		logic               mack;
		logic [7:0]         ptr;
		logic               sda_oe;
		logic               sda_out;
		logic               fifo_take;
		logic [PRESS_W-1:0] press;
		logic [PRESS_W-1:0] press_prev;
		logic [PRESS_W-1:0] press_chg;
		logic [TEMP_W-1:0]  temp;
		logic [TEMP_W-1:0]  temp_prev;
		logic [TEMP_W-1:0]  temp_chg;
		logic               p_rdy;
		logic               p_ow;
		logic               t_rdy;
		logic               t_ow;
	} ptr_bank_t;

	ptr_bank_t  r;
	ptr_bank_t  next_r;
	logic [1:0] pins_s;
	logic       scl_s;
	logic       sda_s;
	logic       scl_rise;
	logic       scl_fall;
	logic       bus_start;
	logic       bus_stop;
	logic       do_load;
	logic       queue_read;
	logic [7:0] load_byte;
	logic [7:0] queue_state;
	logic       q_on;

	// --------------------------------------------------------------------
	// Pin synchroniser and queue state byte
	// --------------------------------------------------------------------
	ptr_sync u_sync (
		.clock    (clock),
		.rstn     (rstn),
		.pin_in   ({sda_in, scl_in}),
		.pin_sync (pins_s)
	);

	ptr_qstat u_qstat (
		.clock                 (clock),
		.rstn                  (rstn),
		.fifo_mode             (fifo_mode),
		.queue_fill_count      (queue_fill_count),
		.queue_overflowed      (queue_overflowed),
		.queue_level_threshold (queue_level_threshold),
		.status_read           (queue_read),
		.queue_state           (queue_state),
		.queue_event_pending   (queue_event_pending)
	);

	// --------------------------------------------------------------------
	// Read map
	// --------------------------------------------------------------------
	// Byte seen by the host at an address; unmapped addresses read zero
	function automatic logic [7:0] byte_at(
		input logic [7:0] a,
		input ptr_bank_t  s,
		input logic       qon,
		input logic [7:0] qdata,
		input logic [7:0] qbyte
	);
		logic [7:0] b;
		b = RESET_BYTE;
		case (a)
			ADDR_READY_FLAGS: begin
				b[RDY_ANY_OW] = s.p_ow | s.t_ow;
				b[RDY_P_OW]   = s.p_ow;
				b[RDY_T_OW]   = s.t_ow;
				b[RDY_ANY]    = s.p_rdy | s.t_rdy;
				b[RDY_P]      = s.p_rdy;
				b[RDY_T]      = s.t_rdy;
			end
			ADDR_PRESS_HI:    b = qon ? qdata : s.press[19:12];
			ADDR_PRESS_MID:   b = qon ? RESET_BYTE : s.press[11:4];
			ADDR_PRESS_LO:    b = qon ? RESET_BYTE : {s.press[3:0], ZERO_NIBBLE};
			ADDR_TEMP_HI:     b = qon ? RESET_BYTE : s.temp[11:4];
			ADDR_TEMP_LO:     b = qon ? RESET_BYTE : {s.temp[3:0], ZERO_NIBBLE};
			ADDR_PCHG_HI:     b = s.press_chg[19:12];
			ADDR_PCHG_MID:    b = s.press_chg[11:4];
			ADDR_PCHG_LO:     b = {s.press_chg[3:0], ZERO_NIBBLE};
			ADDR_TCHG_HI:     b = s.temp_chg[11:4];
			ADDR_TCHG_LO:     b = {s.temp_chg[3:0], ZERO_NIBBLE};
			ADDR_PART_ID:     b = PART_ID;
			ADDR_QUEUE_STATE: b = qbyte;
			default:          b = RESET_BYTE;
		endcase
		return b;
	endfunction

	// --------------------------------------------------------------------
	// Bus events
	// --------------------------------------------------------------------
	// Edges and start/stop come from synchronised levels only
	assign scl_s     = pins_s[0];
	assign sda_s     = pins_s[1];
	assign scl_rise  = scl_s & ~r.scl_d;
	assign scl_fall  = ~scl_s & r.scl_d;
	assign bus_start = scl_s & r.scl_d & r.sda_d & ~sda_s;
	assign bus_stop  = scl_s & r.scl_d & ~r.sda_d & sda_s;
	assign q_on      = (fifo_mode != MODE_OFF);
	assign load_byte = byte_at(r.ptr, r, q_on, fifo_data_byte, queue_state);
	assign queue_read = do_load & (r.ptr == ADDR_QUEUE_STATE);

	// --------------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------------
	// Bus first, then samples, so a sample that lands with a read still sets its flag
	always_comb begin
		next_r           = r;
		do_load          = 1'b0;
		next_r.scl_d     = scl_s;
		next_r.sda_d     = sda_s;
		next_r.fifo_take = 1'b0;
		next_r.sda_out   = 1'b0;  // Open drain: only ever pulls low

		// Byte engine: sample on rising edge, change output on falling edge
		case (r.phase)
			PH_ADDR, PH_PTR, PH_WDATA: begin
				if (scl_rise) begin
					next_r.shreg = {r.shreg[6:0], sda_s};
					next_r.cnt   = r.cnt + 4'h1;
				end else if (scl_fall && r.cnt == BITS_PER_BYTE) begin
					next_r.cnt    = 4'h0;
					next_r.sda_oe = 1'b1;
					if (r.phase == PH_ADDR) begin
						next_r.rw    = r.shreg[0];
						next_r.phase = PH_ACK_ADDR;
						if (r.shreg[7:1] != BUS_ADDRESS) begin
							next_r.sda_oe = 1'b0;
							next_r.phase  = PH_IDLE;
						end
					end else if (r.phase == PH_PTR) begin
						next_r.ptr   = r.shreg;
						next_r.phase = PH_ACK_WR;
					end else begin
						// Data written to this bank is acknowledged and dropped
						next_r.ptr   = r.ptr + 8'h01;
						next_r.phase = PH_ACK_WR;
					end
				end
			end
			PH_ACK_ADDR: begin
				if (scl_fall) begin
					next_r.sda_oe = 1'b0;
					next_r.cnt    = 4'h0;
					if (r.rw) begin
						do_load      = 1'b1;
						next_r.phase = PH_RDATA;
					end else begin
						next_r.phase = PH_PTR;
					end
				end
			end
			PH_ACK_WR: begin
				if (scl_fall) begin
					next_r.sda_oe = 1'b0;
					next_r.cnt    = 4'h0;
					next_r.phase  = PH_WDATA;
				end
			end
			PH_RDATA: begin
				if (scl_rise) begin
					next_r.cnt = r.cnt + 4'h1;
				end else if (scl_fall) begin
					if (r.cnt == BITS_PER_BYTE) begin
						next_r.sda_oe = 1'b0;  // Let the host drive its acknowledge
						next_r.phase  = PH_RACK;
					end else begin
						next_r.shreg  = {r.shreg[6:0], 1'b0};
						next_r.sda_oe = ~r.shreg[6];
					end
				end
			end
			PH_RACK: begin
				if (scl_rise) begin
					next_r.mack = ~sda_s;
				end else if (scl_fall) begin
					next_r.cnt = 4'h0;
					if (r.mack) begin
						do_load      = 1'b1;
						next_r.phase = PH_RDATA;
					end else begin
						next_r.phase = PH_IDLE;
					end
				end
			end
			PH_IDLE: begin
				next_r.sda_oe = 1'b0;
			end
			default: begin
				next_r.phase  = PH_IDLE;
				next_r.sda_oe = 1'b0;
			end
		endcase

		// Load the next read byte; read side effects happen here exactly once
		if (do_load) begin
			next_r.shreg  = load_byte;
			next_r.sda_oe = ~load_byte[7];
			// The queue port does not advance so a burst drains the queue
			if (q_on && r.ptr == ADDR_PRESS_HI) begin
				next_r.fifo_take = 1'b1;
				next_r.p_rdy     = 1'b0;
				next_r.p_ow      = 1'b0;
				next_r.t_rdy     = 1'b0;
				next_r.t_ow      = 1'b0;
			end else begin
				next_r.ptr = r.ptr + 8'h01;
			end
			if (!q_on && r.ptr == ADDR_PRESS_HI) begin
				next_r.p_rdy = 1'b0;
				next_r.p_ow  = 1'b0;
			end
			if (!q_on && r.ptr == ADDR_TEMP_HI) begin
				next_r.t_rdy = 1'b0;
				next_r.t_ow  = 1'b0;
			end
		end

		// Start and stop override any phase; a repeated start keeps the pointer
		if (bus_start) begin
			next_r.phase  = PH_ADDR;
			next_r.cnt    = 4'h0;
			next_r.sda_oe = 1'b0;
		end else if (bus_stop) begin
			next_r.phase  = PH_IDLE;
			next_r.sda_oe = 1'b0;
		end

		// New sample: live results and changes, flags set after any clear
		if (sample_valid) begin
			if (!height_mode_select) begin
				next_r.press      = pressure_value;
				next_r.press_chg  = pressure_value - r.press_prev;
				next_r.press_prev = pressure_value;
				next_r.p_ow       = next_r.p_ow | next_r.p_rdy;
				next_r.p_rdy      = 1'b1;
			end
			next_r.temp      = temperature_value;
			next_r.temp_chg  = temperature_value - r.temp_prev;
			next_r.temp_prev = temperature_value;
			next_r.t_ow      = next_r.t_ow | next_r.t_rdy;
			next_r.t_rdy     = 1'b1;
		end
	end

	// --------------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------------
	// Everything resets to zero but the edge history; the identifier is a constant, not a flop
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			r       <= '0;
			r.scl_d <= 1'b1;  // Idle-high history, so no false clock edge follows reset
			r.sda_d <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign sda_out        = r.sda_out;
	assign sda_oe         = r.sda_oe;
	assign fifo_data_take = r.fifo_take;

	// --------------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------------
	property p_part_id;
		@(posedge clock) disable iff (!rstn)
		(do_load && r.ptr == ADDR_PART_ID) |=> (r.shreg == PART_ID);
	endproperty
	a_part_id: assert property (p_part_id) else $error("identifier byte wrong");

	property p_queue_zero;
		@(posedge clock) disable iff (!rstn)
		(do_load && q_on && r.ptr >= ADDR_PRESS_MID && r.ptr <= ADDR_TEMP_LO) |=> (r.shreg == RESET_BYTE);
	endproperty
	a_queue_zero: assert property (p_queue_zero) else $error("result byte not zero in queue mode");

	property p_press_load;
		@(posedge clock) disable iff (!rstn)
		(sample_valid && !height_mode_select) |=> (r.press == $past(pressure_value));
	endproperty
	a_press_load: assert property (p_press_load) else $error("pressure not loaded");

	property p_temp_change;
		@(posedge clock) disable iff (!rstn)
		sample_valid |=> (r.temp_chg == TEMP_W'($past(temperature_value) - $past(r.temp_prev)));
	endproperty
	a_temp_change: assert property (p_temp_change) else $error("temperature change wrong");

	property p_press_change;
		@(posedge clock) disable iff (!rstn)
		(sample_valid && !height_mode_select) ##1 (!sample_valid)[*2]
		|-> (r.press_chg == PRESS_W'($past(pressure_value, 2) - $past(r.press_prev, 2)));
	endproperty
	a_press_change: assert property (p_press_change) else $error("pressure change wrong");

	property p_ready_clear;
		@(posedge clock) disable iff (!rstn)
		(do_load && !q_on && r.ptr == ADDR_PRESS_HI && !sample_valid) |=> (!r.p_rdy && !r.p_ow);
	endproperty
	a_ready_clear: assert property (p_ready_clear) else $error("pressure flags not cleared");

	property p_auto_inc;
		@(posedge clock) disable iff (!rstn)
		(do_load && !q_on) |=> (r.ptr == 8'($past(r.ptr) + 8'h01));
	endproperty
	a_auto_inc: assert property (p_auto_inc) else $error("pointer did not advance");

	property p_low_nibble;
		@(posedge clock) disable iff (!rstn)
		(do_load && (r.ptr == ADDR_PRESS_LO || r.ptr == ADDR_TEMP_LO || r.ptr == ADDR_TCHG_LO))
		|=> (r.shreg[3:0] == ZERO_NIBBLE);
	endproperty
	a_low_nibble: assert property (p_low_nibble) else $error("reserved nibble not zero");

	property p_queue_byte;
		@(posedge clock) disable iff (!rstn)
		queue_read |=> (r.shreg == $past(queue_state));
	endproperty
	a_queue_byte: assert property (p_queue_byte) else $error("queue state byte wrong");

endmodule // ptr_result_bank

// file: ptr_pkg.sv
/*
 * Shared constants and types for the pressure and temperature result bank.
 * Assumes a single 25 MHz system clock; the serial bus pins arrive unsynchronised.
 */
package ptr_pkg;

	// --------------------------------------------------------------------
	// Widths
	// --------------------------------------------------------------------
	localparam int PRESS_W = 20;               // Unsigned 18.2 pascals
	localparam int TEMP_W  = 12;               // Signed 8.4 degrees
	localparam int CNT_W   = 6;                // Queue sample count

	// --------------------------------------------------------------------
	// Register offsets
	// --------------------------------------------------------------------
	localparam logic [7:0] ADDR_READY_FLAGS   = 8'h00;
	localparam logic [7:0] ADDR_PRESS_HI      = 8'h01;
	localparam logic [7:0] ADDR_PRESS_MID     = 8'h02;
	localparam logic [7:0] ADDR_PRESS_LO      = 8'h03;
	localparam logic [7:0] ADDR_TEMP_HI       = 8'h04;
	localparam logic [7:0] ADDR_TEMP_LO       = 8'h05;
	localparam logic [7:0] ADDR_PCHG_HI       = 8'h07;
	localparam logic [7:0] ADDR_PCHG_MID      = 8'h08;
	localparam logic [7:0] ADDR_PCHG_LO       = 8'h09;
	localparam logic [7:0] ADDR_TCHG_HI       = 8'h0A;
	localparam logic [7:0] ADDR_TCHG_LO       = 8'h0B;
	localparam logic [7:0] ADDR_PART_ID       = 8'h0C;
	localparam logic [7:0] ADDR_QUEUE_STATE   = 8'h0D;

	// --------------------------------------------------------------------
	// Reset values and identity
	// --------------------------------------------------------------------
	localparam logic [7:0] RESET_BYTE         = 8'h00;
	localparam logic [3:0] ZERO_NIBBLE        = 4'h0;
	localparam logic [6:0] BUS_ADDRESS_DFLT   = 7'h2A;  // Arbitrary value
	localparam logic [7:0] PART_ID_DFLT       = 8'h5A;  // Arbitrary value

	// --------------------------------------------------------------------
	// Field positions
	// --------------------------------------------------------------------
	localparam int RDY_ANY_OW = 7;
	localparam int RDY_P_OW   = 6;
	localparam int RDY_T_OW   = 5;
	localparam int RDY_ANY    = 3;
	localparam int RDY_P      = 2;
	localparam int RDY_T      = 1;
	localparam int QS_OVF     = 7;
	localparam int QS_LEVEL   = 6;

	// --------------------------------------------------------------------
	// Modes, counts and bus phases
	// --------------------------------------------------------------------
	localparam logic [1:0] MODE_OFF      = 2'b00;
	localparam logic [5:0] CNT_EMPTY     = 6'h00;
	localparam logic [5:0] CNT_FULL      = 6'h20;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [2:0] {
		PH_IDLE,
		PH_ADDR,
		PH_ACK_ADDR,
		PH_PTR,
		PH_ACK_WR,
		PH_WDATA,
		PH_RDATA,
		PH_RACK
	} ptr_phase_t;

endpackage

// file: ptr_sync.sv
/*
 * Two-flop synchroniser for the serial clock and data pins.
 * Assumes the pins are asynchronous to clock; only the second stage is read outside.
 */
`timescale 1ns/1ns
module ptr_sync (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rstn,
	// Pins in, synchronised levels out
	input  wire logic [1:0] pin_in,
	output logic      [1:0] pin_sync
);
	import ptr_pkg::*;

	typedef struct packed {
		logic [1:0] stage1;
		logic [1:0] stage2;
	} ptr_sync_t;

	ptr_sync_t r;
	ptr_sync_t next_r;

	// First stage feeds only the second stage
	always_comb begin
		next_r        = r;
		next_r.stage1 = pin_in;
		next_r.stage2 = r.stage1;
	end

	// Idle bus is high, so the pipeline resets high to avoid a false start
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			r <= '1;
		end else begin
			r <= next_r;
		end
	end

	assign pin_sync = r.stage2;

endmodule // ptr_sync

// file: ptr_qstat.sv
/*
 * Queue state byte: overflow flag, level flag and sample count, plus the
 * pending queue event bit that a read of the byte clears.
 * Assumes the queue itself lives elsewhere on the same clock.
 */
`timescale 1ns/1ns
module ptr_qstat (
	// Clock and reset
	input  wire logic                   clock,
	input  wire logic                   rstn,
	// Queue condition from the sample store
	input  wire logic [1:0]             fifo_mode,
	input  wire logic [ptr_pkg::CNT_W-1:0] queue_fill_count,
	input  wire logic                   queue_overflowed,
	input  wire logic [ptr_pkg::CNT_W-1:0] queue_level_threshold,
	// Read of the byte and results
	input  wire logic                   status_read,
	output logic      [7:0]             queue_state,
	output logic                        queue_event_pending
);
	import ptr_pkg::*;

	typedef struct packed {
		logic [7:0] qbyte;
		logic       pend;
	} ptr_qs_t;

	ptr_qs_t r;
	ptr_qs_t next_r;
	logic    q_on;

	// Flags track their conditions; disabled queue reads all zero
	always_comb begin
		next_r = r;
		q_on   = (fifo_mode != MODE_OFF);
		next_r.qbyte[QS_OVF]   = q_on & queue_overflowed;
		next_r.qbyte[QS_LEVEL] = q_on & (queue_fill_count > queue_level_threshold);
		next_r.qbyte[CNT_W-1:0] = q_on ? queue_fill_count : CNT_EMPTY;
		// Read clears only the pending bit; a new event in the same cycle wins
		if (status_read) begin
			next_r.pend = 1'b0;
		end
		if ((next_r.qbyte[QS_OVF] & ~r.qbyte[QS_OVF]) | (next_r.qbyte[QS_LEVEL] & ~r.qbyte[QS_LEVEL])) begin
			next_r.pend = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign queue_state         = r.qbyte;
	assign queue_event_pending = r.pend;

	// --------------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------------
	property p_ovf_follows;
		@(posedge clock) disable iff (!rstn)
		(fifo_mode != MODE_OFF && queue_overflowed) |=> queue_state[QS_OVF];
	endproperty
	a_ovf_follows: assert property (p_ovf_follows) else $error("overflow flag missing");

	property p_level_follows;
		@(posedge clock) disable iff (!rstn)
		(fifo_mode != MODE_OFF) |=> (queue_state[QS_LEVEL] == $past(queue_fill_count > queue_level_threshold));
	endproperty
	a_level_follows: assert property (p_level_follows) else $error("level flag wrong");

	property p_off_zero;
		@(posedge clock) disable iff (!rstn)
		(fifo_mode == MODE_OFF) |=> (queue_state == RESET_BYTE);
	endproperty
	a_off_zero: assert property (p_off_zero) else $error("disabled queue byte not zero");

	property p_read_keeps_flags;
		@(posedge clock) disable iff (!rstn)
		(status_read && fifo_mode != MODE_OFF && queue_overflowed && !queue_state[QS_OVF] == 1'b0)
		|=> queue_state[QS_OVF] && !$changed(queue_state[QS_OVF]);
	endproperty
	a_read_keeps_flags: assert property (p_read_keeps_flags) else $error("read cleared overflow");

endmodule // ptr_qstat

// file: ptr_host.sv
/*
 * Serial bus controller model: drives the bus clock and pulls data low.
 * Assumes the bench resolves the data wire from both pull-down enables.
 */
`timescale 1ns/1ns
module ptr_host (
	// Bus pins
	output logic      scl,
	output logic      host_oe,
	input  wire logic sda
);
	// Idle bus: both lines released, clock stands high
	initial begin
		scl = 1'b1;
		host_oe = 1'b0;
	end
	// One bit; data moves mid-low so the slave's sync delay never sees it move near a rise
	task automatic bit_io(input logic b, output logic r);
		#80 host_oe = !b;
		#120 r = sda;
		scl = 1'b1;
		#120 scl = 1'b0;
	endtask
	// Start or repeated start; clock left low
	task automatic start();
		#80 host_oe = 1'b0;
		#120 scl = 1'b1;
		#120 host_oe = 1'b1;
		#120 scl = 1'b0;
	endtask
	// Stop; clock left high between frames
	task automatic stop();
		#80 host_oe = 1'b1;
		#120 scl = 1'b1;
		#120 host_oe = 1'b0;
	endtask
	// Byte out or in, most significant first, then the ninth bit
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic ra);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r[i]);
		bit_io(a, ra);
	endtask
endmodule // ptr_host

// file: testbench.sv
/*
 * Bench for the result bank: random samples and queue states read back over the bus.
 * Assumes the controller model and the bank share one pulled-up data wire.
 */
`timescale 1ns/1ns
module testbench;
	import ptr_pkg::*;
	localparam logic [7:0] ID = 8'hA7;  // Arbitrary value
	localparam logic [7:0] AW = {BUS_ADDRESS_DFLT, 1'b0};
	logic        clock = 1'b0;
	logic        rstn = 1'b0;
	logic        sample_valid, height_mode_select, queue_overflowed, sda_oe, scl, host_oe, ack;
	logic        fifo_data_take, queue_event_pending, sdo;
	logic [19:0] pressure_value, p, dp;
	logic [11:0] temperature_value, t, dt;
	logic [1:0]  fifo_mode;
	logic [5:0]  cnt, thr;
	logic [7:0]  fb, r;
	logic [7:0]  rb [0:13];
	int          errors, total_checks, takes, seed;
	wire logic   sda = !(sda_oe | host_oe);  // Open drain with pull-up

	ptr_result_bank #(.PART_ID(ID)) uut (.clock, .rstn, .scl_in(scl), .sda_in(sda), .sda_out(sdo), .sda_oe,
		.sample_valid, .pressure_value, .temperature_value, .height_mode_select, .fifo_mode,
		.queue_level_threshold(thr), .queue_fill_count(cnt), .queue_overflowed, .fifo_data_byte(fb),
		.fifo_data_take, .queue_event_pending);
	ptr_host host (.scl, .host_oe, .sda);

	always #20 clock = ~clock;
	always @(posedge clock) if (fifo_data_take === 1'b1) takes++;

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic final_report();
		if (errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Expected byte at an address with the queue off, queue byte in any mode
	function automatic logic [7:0] exp_byte(input logic [7:0] a);
		case (a)
			8'h01: return p[19:12];
			8'h02: return p[11:4];
			8'h03: return {p[3:0], 4'h0};
			8'h04: return t[11:4];
			8'h05: return {t[3:0], 4'h0};
			8'h07: return dp[19:12];
			8'h08: return dp[11:4];
			8'h09: return {dp[3:0], 4'h0};
			8'h0A: return dt[11:4];
			8'h0B: return {dt[3:0], 4'h0};
			8'h0C: return ID;
			8'h0D: return fifo_mode == 2'b00 ? 8'h00 : {queue_overflowed, cnt > thr, cnt};
			default: return 8'h00;
		endcase
	endfunction
	// Address phase plus register pointer
	task automatic setp(input logic [7:0] ptr);
		host.start();
		host.xfer(AW, 1'b1, r, ack);
		chk({7'h0, ack}, 8'h00);
		host.xfer(ptr, 1'b1, r, ack);
		chk({7'h0, ack}, 8'h00);
	endtask
	// Burst read of n bytes, last one refused
	task automatic rd(input logic [7:0] ptr, input int n);
		setp(ptr);
		host.start();
		host.xfer(AW | 8'h01, 1'b1, r, ack);
		chk({7'h0, ack}, 8'h00);
		for (int i = 0; i < n; i++)
			host.xfer(8'hFF, i == n - 1, rb[i], ack);
		host.stop();
	endtask
	// One sample pulse; pressure and its change freeze in height mode
	task automatic sample();
		@(posedge clock) #1;
		pressure_value = 20'($random(seed));
		temperature_value = 12'($random(seed));
		sample_valid = 1'b1;
		@(posedge clock) #1 sample_valid = 1'b0;
		dt = temperature_value - t;
		t = temperature_value;
		if (!height_mode_select) begin
			dp = pressure_value - p;
			p = pressure_value;
		end
	endtask

	initial begin
		repeat (80000) @(posedge clock);
		errors++;
		final_report();
	end
	initial begin
		seed = 32'hFC08_6471;
		{sample_valid, height_mode_select, queue_overflowed, fifo_mode, cnt, thr, fb} = 0;
		{pressure_value, temperature_value, p, dp, t, dt} = 0;
		repeat (5) @(posedge clock);
		chk({4'h0, sdo, fifo_data_take, sda_oe, queue_event_pending}, 8'h00);
		#1 rstn = 1'b1;
		repeat (4) @(posedge clock);
		#1 host.start();
		host.xfer(AW ^ 8'h02, 1'b1, r, ack);
		chk({7'h0, ack}, 8'h01);
		host.stop();
		for (int i = 0; i < 2; i++) begin
			setp(i ? 8'h0C : 8'h01);
			host.xfer(8'($random(seed)), 1'b1, r, ack);
			host.stop();
		end
		rd(8'h00, 14);
		for (int a = 0; a < 14; a++) chk(rb[a], exp_byte(8'(a)));
		for (int it = 0; it < 8; it++) begin
			@(posedge clock) #1 fifo_mode = 2'b00;
			height_mode_select = (it == 3);
			cnt = (it == 7) ? CNT_FULL : 6'($unsigned($random(seed)) % 33);
			thr = (it == 6) ? cnt : 6'($random(seed));
			queue_overflowed = 1'($random(seed));
			fb = 8'($random(seed));
			repeat (3) @(posedge clock);
			sample();
			if (it == 1) sample();
			if (it < 5) begin
				rd(8'h00, 14);
				for (int a = 1; a < 14; a++) chk(rb[a], exp_byte(8'(a)));
				if (it != 3) chk(rb[0] & 8'h44, it == 1 ? 8'h44 : 8'h04);
				chk({6'h0, sdo, queue_event_pending}, 8'h00);
			end else begin
				@(posedge clock) #1 fifo_mode = 2'(it - 4);
				repeat (3) @(posedge clock);
				#1 chk({7'h0, queue_event_pending}, {7'h0, queue_overflowed | (cnt > thr)});
				takes = 0;
				rd(8'h01, 3);
				for (int i = 0; i < 3; i++) chk(rb[i], fb);
				chk(8'(takes), 8'h03);
				rd(8'h02, 4);
				for (int i = 0; i < 4; i++) chk(rb[i], 8'h00);
				rd(8'h07, 7);
				for (int i = 0; i < 7; i++) chk(rb[i], exp_byte(8'(i + 7)));
				chk({7'h0, queue_event_pending}, 8'h00);
				rd(8'h0D, 1);
				chk(rb[0], exp_byte(8'h0D));
			end
		end
		final_report();
	end
endmodule // testbench
